/* File: design/alarm_channel.sv */
// One alarm channel: static level or rate-of-change comparison.
`timescale 1ns/1ps
module alarm_channel #(
  parameter int CNT_W  = 8,
  parameter int DATA_W = 16
) (
  input  wire logic clk,
  input  wire logic rst,
  alarm_if.chan     alm
);

  // ********************************************************************
  // Elaboration check.
  // ********************************************************************
  if (CNT_W != 8 || DATA_W != 16) begin : g_check
    $error("alarm_channel supports only CNT_W 8 and DATA_W 16");
  end

  logic [15:0] ref_q, ref_d;
  logic [7:0]  cnt_q, cnt_d;
  logic        primed_q, primed_d;
  logic        flag_q, flag_d;
  logic [15:0] value;
  logic [7:0]  needed;
  logic [16:0] delta;
  logic [15:0] mag;
  logic        is_signed;
  logic        greater;
  logic        less;

  // ********************************************************************
  // Comparison.
  // ********************************************************************
  always_comb begin
    ref_d    = ref_q;
    cnt_d    = cnt_q;
    primed_d = primed_q;
    flag_d   = flag_q;
    case (alm.source)
      gyro_cal_pkg::SRC_RATE:   value = alm.rate_word;
      gyro_cal_pkg::SRC_TEMP:   value = alm.temp_word;
      gyro_cal_pkg::SRC_STATUS: value = alm.status_word;
      default:                  value = 16'h0000;
    endcase
    is_signed = (alm.source != gyro_cal_pkg::SRC_STATUS);
    greater   = is_signed ? ($signed(value) > $signed(alm.threshold)) : (value > alm.threshold);
    less      = is_signed ? ($signed(value) < $signed(alm.threshold)) : (value < alm.threshold);
    needed    = (alm.sample_count == 8'h00) ? gyro_cal_pkg::CNT_ONE : alm.sample_count;
    delta     = {value[15] & is_signed, value} - {ref_q[15] & is_signed, ref_q};
    mag       = delta[16] ? 16'(~delta + 17'h00001) : delta[15:0];
    if (alm.source == gyro_cal_pkg::SRC_OFF) begin
      flag_d   = 1'b0;
      primed_d = 1'b0;
      cnt_d    = 8'h00;
    end else if (alm.sample) begin
      if (!alm.rate_of_change) begin
        flag_d   = alm.above ? greater : less;
        primed_d = 1'b0;
      end else if (!primed_q) begin
        ref_d    = value;
        primed_d = 1'b1;
        cnt_d    = 8'h00;
      end else if (cnt_q + 8'h01 >= needed) begin
        flag_d = alm.above ? (mag > alm.threshold) : (mag < alm.threshold);
        ref_d  = value;
        cnt_d  = 8'h00;
      end else begin
        cnt_d = cnt_q + 8'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ref_q    <= 16'h0000;
      cnt_q    <= 8'h00;
      primed_q <= 1'b0;
      flag_q   <= 1'b0;
    end else begin
      ref_q    <= ref_d;
      cnt_q    <= cnt_d;
      primed_q <= primed_d;
      flag_q   <= flag_d;
    end
  end

  assign alm.flag = flag_q;

endmodule

/* File: design/alarm_if.sv */
// Interface between the register core and one alarm channel.
`timescale 1ns/1ps
interface alarm_if;
  logic        sample;
  logic [3:0]  source;
  logic        rate_of_change;
  logic        above;
  logic [15:0] threshold;
  logic [7:0]  sample_count;
  logic [15:0] rate_word;
  logic [15:0] temp_word;
  logic [15:0] status_word;
  logic        flag;

  modport ctrl (output sample, source, rate_of_change, above, threshold, sample_count,
                rate_word, temp_word, status_word, input flag);
  modport chan (input sample, source, rate_of_change, above, threshold, sample_count,
                rate_word, temp_word, status_word, output flag);
endinterface

/* File: design/gyro_cal_alarm.sv */
// Bias calibration, alarm monitor and serial register port of the rate sensor.
//
// Operation
// - Writing bit 0 of the command register starts bias null; bit clears when done.
// - Bias null waits 2^decimation output samples, negates rate output, loads offsets, commits.
// - Bias null period follows decimation; setting 0x10 waits 65,536 samples.
// - Serial frames are ignored while bias null runs; only reset aborts it.
// - Upper offset is two's complement correction added to the rate output.
// - Lower offset holds the fractional extension bits of the correction.
// - Restore command clears calibration registers, zeroes data, commits to flash.
// - Two alarm channels evaluate independently with their own settings.
// - Source codes per alarm: disabled, upper rate word, temperature, status.
// - Configuration bits 7 and 6 choose rate-of-change or static comparison.
// - Configuration bits 5 and 4 choose trigger above or below threshold.
// - Configuration bit 3 selects filtered rate data for rate sources only.
// - Bits 2..0 enable indicator, set its polarity and choose its pin.
// - Static mode compares the source with the threshold in the source format.
// - Rate-of-change mode compares change over the sample count with threshold.
// - Sample count uses bits 7..0; zero and one both mean one sample.
// - Alarm flags appear in bits 9..8 of the status register.
// - Each register spans two byte addresses; upper byte at address plus one.
`timescale 1ns/1ps
module gyro_cal_alarm (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        din,
  output logic             dout,
  output logic             dout_oe,
  input  wire logic        sample_valid,
  input  wire logic [31:0] rate_raw,
  input  wire logic [31:0] rate_filtered,
  input  wire logic [15:0] temp_word,
  input  wire logic [7:0]  status_word,
  input  wire logic [4:0]  decimation_setting,
  output logic [15:0]      rate_output_high,
  output logic [15:0]      rate_output_low,
  output logic             flash_commit,
  output logic             data_clear,
  output logic             auto_bias_busy,
  output logic             digital_io_first_out,
  output logic             digital_io_first_oe,
  output logic             digital_io_second_out,
  output logic             digital_io_second_oe
);

  // ********************************************************************
  // Pin synchronisers; a pin changes once the second and third stage agree.
  // ********************************************************************
  localparam logic [2:0] PIN_IDLE = 3'b110;

  logic [2:0] sync1_q, sync2_q, sync3_q;
  logic [2:0] pins_q, pins_d;

  always_comb begin
    pins_d = (~(sync2_q ^ sync3_q) & sync2_q) | ((sync2_q ^ sync3_q) & pins_q);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_q <= PIN_IDLE;
      sync2_q <= PIN_IDLE;
      sync3_q <= PIN_IDLE;
      pins_q  <= PIN_IDLE;
    end else begin
      sync1_q <= {sclk, cs_n, din};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      pins_q  <= pins_d;
    end
  end

  // ********************************************************************
  // Register state.
  // ********************************************************************
  logic [4:0]                   bit_cnt_q, bit_cnt_d;
  logic [15:0]                  rx_q, rx_d;
  logic [15:0]                  tx_q, tx_d;
  logic                         dout_q, dout_d;
  logic [6:0]                   rd_addr_q, rd_addr_d;
  logic [15:0]                  off_high_q, off_high_d;
  logic [15:0]                  off_low_q, off_low_d;
  logic [15:0]                  thr1_q, thr1_d;
  logic [15:0]                  thr2_q, thr2_d;
  logic [15:0]                  cnt1_q, cnt1_d;
  logic [15:0]                  cnt2_q, cnt2_d;
  logic [15:0]                  cfg_q, cfg_d;
  logic [31:0]                  rate_q, rate_d;
  logic [15:0]                  filt_high_q, filt_high_d;
  logic                         sample_q, sample_d;
  logic                         commit_q, commit_d;
  logic                         clear_q, clear_d;
  logic [16:0]                  avg_cnt_q, avg_cnt_d;
  gyro_cal_pkg::null_state_type state_q, state_d;
  logic                         cs_fall, cs_rise, sclk_rise, sclk_fall, active;
  logic                         frame_ok, wr_hi;
  logic [6:0]                   wr_addr;
  logic [7:0]                   wr_byte;
  logic [16:0]                  avg_target;
  logic [31:0]                  offset_full;
  logic [31:0]                  filt_sum;
  logic [15:0]                  rd_word;
  logic [15:0]                  status_full;
  logic                         alarm1_flag, alarm2_flag;

  function automatic logic [15:0] put_byte(input logic [15:0] old, input logic hi,
                                           input logic [7:0] b);
    put_byte = hi ? {b, old[7:0]} : {old[15:8], b};
  endfunction

  assign offset_full = {off_high_q, off_low_q};
  assign status_full = {6'h00, alarm2_flag, alarm1_flag, status_word};

  // ********************************************************************
  // Read multiplexer over the word that holds the addressed byte.
  // ********************************************************************
  always_comb begin
    case ({rd_addr_q[6:1], 1'b0})
      gyro_cal_pkg::ADDR_TEMP:       rd_word = temp_word;
      gyro_cal_pkg::ADDR_RATE_LOW:   rd_word = rate_q[15:0];
      gyro_cal_pkg::ADDR_RATE_HIGH:  rd_word = rate_q[31:16];
      gyro_cal_pkg::ADDR_OFF_LOW:    rd_word = off_low_q;
      gyro_cal_pkg::ADDR_OFF_HIGH:   rd_word = off_high_q;
      gyro_cal_pkg::ADDR_ALM1_THR:   rd_word = thr1_q;
      gyro_cal_pkg::ADDR_ALM2_THR:   rd_word = thr2_q;
      gyro_cal_pkg::ADDR_ALM1_CNT:   rd_word = cnt1_q;
      gyro_cal_pkg::ADDR_ALM2_CNT:   rd_word = cnt2_q;
      gyro_cal_pkg::ADDR_ALM_CFG:    rd_word = cfg_q;
      gyro_cal_pkg::ADDR_STATUS:     rd_word = status_full;
      default:                       rd_word = 16'h0000;
    endcase
  end

  // ********************************************************************
  // Serial frames, registers, bias null sequence and corrected output.
  // ********************************************************************
  always_comb begin
    bit_cnt_d   = bit_cnt_q;
    rx_d        = rx_q;
    tx_d        = tx_q;
    dout_d      = dout_q;
    rd_addr_d   = rd_addr_q;
    off_high_d  = off_high_q;
    off_low_d   = off_low_q;
    thr1_d      = thr1_q;
    thr2_d      = thr2_q;
    cnt1_d      = cnt1_q;
    cnt2_d      = cnt2_q;
    cfg_d       = cfg_q;
    rate_d      = rate_q;
    filt_high_d = filt_high_q;
    avg_cnt_d   = avg_cnt_q;
    state_d     = state_q;
    sample_d    = sample_valid;
    commit_d    = 1'b0;
    clear_d     = 1'b0;
    active      = ~pins_q[1];
    cs_fall     = pins_q[1] & ~pins_d[1];
    cs_rise     = ~pins_q[1] & pins_d[1];
    sclk_rise   = ~pins_q[2] & pins_d[2];
    sclk_fall   = pins_q[2] & ~pins_d[2];
    wr_addr     = rx_q[14:8];
    wr_byte     = rx_q[7:0];
    wr_hi       = rx_q[8];
    frame_ok    = cs_rise && (bit_cnt_q == gyro_cal_pkg::FRAME_LEN)
                  && (state_q == gyro_cal_pkg::ST_IDLE);
    avg_target  = 17'h00001 << ((decimation_setting > gyro_cal_pkg::DEC_MAX)
                  ? gyro_cal_pkg::DEC_MAX : decimation_setting);
    filt_sum    = rate_filtered + offset_full;

    if (state_q == gyro_cal_pkg::ST_IDLE) begin
      if (cs_fall) begin
        bit_cnt_d = 5'h00;
        tx_d      = rd_word;
      end else if (active && sclk_rise && bit_cnt_q < gyro_cal_pkg::FRAME_LEN) begin
        rx_d      = {rx_q[14:0], pins_d[0]};
        bit_cnt_d = bit_cnt_q + 5'h01;
      end else if (active && sclk_fall) begin
        dout_d = tx_q[15];
        tx_d   = {tx_q[14:0], 1'b0};
      end
    end

    if (frame_ok && !rx_q[gyro_cal_pkg::FRAME_WRITE]) begin
      rd_addr_d = rx_q[14:8];
    end else if (frame_ok) begin
      case ({wr_addr[6:1], 1'b0})
        gyro_cal_pkg::ADDR_OFF_LOW:  off_low_d  = put_byte(off_low_q, wr_hi, wr_byte);
        gyro_cal_pkg::ADDR_OFF_HIGH: off_high_d = put_byte(off_high_q, wr_hi, wr_byte);
        gyro_cal_pkg::ADDR_ALM1_THR: thr1_d     = put_byte(thr1_q, wr_hi, wr_byte);
        gyro_cal_pkg::ADDR_ALM2_THR: thr2_d     = put_byte(thr2_q, wr_hi, wr_byte);
        gyro_cal_pkg::ADDR_ALM1_CNT: cnt1_d     = put_byte(cnt1_q, wr_hi, wr_byte);
        gyro_cal_pkg::ADDR_ALM2_CNT: cnt2_d     = put_byte(cnt2_q, wr_hi, wr_byte);
        gyro_cal_pkg::ADDR_ALM_CFG:  cfg_d      = put_byte(cfg_q, wr_hi, wr_byte);
        gyro_cal_pkg::ADDR_GLOBAL_CMD: begin
          if (!wr_hi && wr_byte[gyro_cal_pkg::CMD_RESTORE]) begin
            off_low_d  = gyro_cal_pkg::RESET_WORD;
            off_high_d = gyro_cal_pkg::RESET_WORD;
            rate_d     = 32'h00000000;
            filt_high_d = 16'h0000;
            clear_d    = 1'b1;
            commit_d   = 1'b1;
          end else if (!wr_hi && wr_byte[gyro_cal_pkg::CMD_AUTO_NULL]) begin
            state_d   = gyro_cal_pkg::ST_AVERAGE;
            avg_cnt_d = 17'h00000;
          end
        end
        default: ;
      endcase
    end

    case (state_q)
      gyro_cal_pkg::ST_IDLE: ;
      gyro_cal_pkg::ST_AVERAGE: begin
        if (sample_valid) begin
          avg_cnt_d = avg_cnt_q + 17'h00001;
          if (avg_cnt_q + 17'h00001 >= avg_target) begin
            {off_high_d, off_low_d} = 32'h00000000 - (rate_raw + offset_full);
            state_d = gyro_cal_pkg::ST_COMMIT;
          end
        end
      end
      gyro_cal_pkg::ST_COMMIT: begin
        commit_d = 1'b1;
        state_d  = gyro_cal_pkg::ST_IDLE;
      end
      default: state_d = gyro_cal_pkg::ST_IDLE;
    endcase

    if (sample_valid && !clear_d) begin
      rate_d      = rate_raw + offset_full;
      filt_high_d = filt_sum[31:16];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      bit_cnt_q   <= 5'h00;
      rx_q        <= 16'h0000;
      tx_q        <= 16'h0000;
      dout_q      <= 1'b0;
      rd_addr_q   <= 7'h00;
      off_high_q  <= gyro_cal_pkg::RESET_WORD;
      off_low_q   <= gyro_cal_pkg::RESET_WORD;
      thr1_q      <= gyro_cal_pkg::RESET_WORD;
      thr2_q      <= gyro_cal_pkg::RESET_WORD;
      cnt1_q      <= gyro_cal_pkg::RESET_WORD;
      cnt2_q      <= gyro_cal_pkg::RESET_WORD;
      cfg_q       <= gyro_cal_pkg::RESET_WORD;
      rate_q      <= 32'h00000000;
      filt_high_q <= 16'h0000;
      sample_q    <= 1'b0;
      commit_q    <= 1'b0;
      clear_q     <= 1'b0;
      avg_cnt_q   <= 17'h00000;
      state_q     <= gyro_cal_pkg::ST_IDLE;
    end else begin
      bit_cnt_q   <= bit_cnt_d;
      rx_q        <= rx_d;
      tx_q        <= tx_d;
      dout_q      <= dout_d;
      rd_addr_q   <= rd_addr_d;
      off_high_q  <= off_high_d;
      off_low_q   <= off_low_d;
      thr1_q      <= thr1_d;
      thr2_q      <= thr2_d;
      cnt1_q      <= cnt1_d;
      cnt2_q      <= cnt2_d;
      cfg_q       <= cfg_d;
      rate_q      <= rate_d;
      filt_high_q <= filt_high_d;
      sample_q    <= sample_d;
      commit_q    <= commit_d;
      clear_q     <= clear_d;
      avg_cnt_q   <= avg_cnt_d;
      state_q     <= state_d;
    end
  end

  assign dout             = dout_q;
  assign dout_oe          = active && (state_q == gyro_cal_pkg::ST_IDLE);
  assign rate_output_high = rate_q[31:16];
  assign rate_output_low  = rate_q[15:0];
  assign flash_commit     = commit_q;
  assign data_clear       = clear_q;
  assign auto_bias_busy   = (state_q != gyro_cal_pkg::ST_IDLE);

  // ********************************************************************
  // Alarm channels.
  // ********************************************************************
  alarm_if alm1 ();
  alarm_if alm2 ();

  always_comb begin
    alm1.sample         = sample_q;
    alm1.source         = cfg_q[gyro_cal_pkg::CFG_SRC1_LSB +: 4];
    alm1.rate_of_change = cfg_q[gyro_cal_pkg::CFG_ROC1];
    alm1.above          = cfg_q[gyro_cal_pkg::CFG_ABOVE1];
    alm1.threshold      = thr1_q;
    alm1.sample_count   = cnt1_q[7:0];
    alm1.rate_word      = cfg_q[gyro_cal_pkg::CFG_FILTER] ? filt_high_q : rate_q[31:16];
    alm1.temp_word      = temp_word;
    alm1.status_word    = status_full;
    alm2.sample         = sample_q;
    alm2.source         = cfg_q[gyro_cal_pkg::CFG_SRC2_LSB +: 4];
    alm2.rate_of_change = cfg_q[gyro_cal_pkg::CFG_ROC2];
    alm2.above          = cfg_q[gyro_cal_pkg::CFG_ABOVE2];
    alm2.threshold      = thr2_q;
    alm2.sample_count   = cnt2_q[7:0];
    alm2.rate_word      = cfg_q[gyro_cal_pkg::CFG_FILTER] ? filt_high_q : rate_q[31:16];
    alm2.temp_word      = temp_word;
    alm2.status_word    = status_full;
  end

  alarm_channel #(.CNT_W(8), .DATA_W(16)) u_alarm1 (
    .clk (clk),
    .rst (rst),
    .alm (alm1)
  );

  alarm_channel #(.CNT_W(8), .DATA_W(16)) u_alarm2 (
    .clk (clk),
    .rst (rst),
    .alm (alm2)
  );

  assign alarm1_flag = alm1.flag;
  assign alarm2_flag = alm2.flag;

  // ********************************************************************
  // Alarm indicator pins.
  // ********************************************************************
  logic [3:0] dio_q, dio_d;
  logic       level;

  always_comb begin
    level = cfg_q[gyro_cal_pkg::CFG_IND_POL] ? (alarm1_flag | alarm2_flag)
                                             : ~(alarm1_flag | alarm2_flag);
    dio_d = 4'h0;
    if (cfg_q[gyro_cal_pkg::CFG_IND_EN]) begin
      if (cfg_q[gyro_cal_pkg::CFG_IND_SEL]) begin
        dio_d = {level, 1'b1, 2'b00};
      end else begin
        dio_d = {2'b00, level, 1'b1};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      dio_q <= 4'h0;
    end else begin
      dio_q <= dio_d;
    end
  end

  assign digital_io_first_out  = dio_q[1];
  assign digital_io_first_oe   = dio_q[0];
  assign digital_io_second_out = dio_q[3];
  assign digital_io_second_oe  = dio_q[2];

endmodule

/* File: design/gyro_cal_pkg.sv */
// Shared constants and types for the bias calibration and alarm monitor.
package gyro_cal_pkg;

  // ********************************************************************
  // Register byte addresses (lower byte of each 16-bit register).
  // ********************************************************************
  localparam logic [6:0] ADDR_TEMP       = 7'h02;
  localparam logic [6:0] ADDR_RATE_LOW   = 7'h04;
  localparam logic [6:0] ADDR_RATE_HIGH  = 7'h06;
  localparam logic [6:0] ADDR_OFF_LOW    = 7'h08;
  localparam logic [6:0] ADDR_OFF_HIGH   = 7'h0a;
  localparam logic [6:0] ADDR_ALM1_THR   = 7'h10;
  localparam logic [6:0] ADDR_ALM2_THR   = 7'h12;
  localparam logic [6:0] ADDR_ALM1_CNT   = 7'h14;
  localparam logic [6:0] ADDR_ALM2_CNT   = 7'h16;
  localparam logic [6:0] ADDR_ALM_CFG    = 7'h18;
  localparam logic [6:0] ADDR_STATUS     = 7'h26;
  localparam logic [6:0] ADDR_GLOBAL_CMD = 7'h28;

  // ********************************************************************
  // Reset values and field positions.
  // ********************************************************************
  localparam logic [15:0] RESET_WORD  = 16'h0000;
  localparam int          CMD_AUTO_NULL = 0;
  localparam int          CMD_RESTORE   = 1;
  localparam int          CFG_SRC2_LSB  = 12;
  localparam int          CFG_SRC1_LSB  = 8;
  localparam int          CFG_ROC2      = 7;
  localparam int          CFG_ROC1      = 6;
  localparam int          CFG_ABOVE2    = 5;
  localparam int          CFG_ABOVE1    = 4;
  localparam int          CFG_FILTER    = 3;
  localparam int          CFG_IND_EN    = 2;
  localparam int          CFG_IND_POL   = 1;
  localparam int          CFG_IND_SEL   = 0;
  localparam int          STAT_ALM1     = 8;
  localparam int          STAT_ALM2     = 9;
  localparam int          FRAME_WRITE   = 15;
  localparam logic [4:0]  FRAME_LEN     = 5'h10;
  localparam logic [4:0]  DEC_MAX       = 5'h10;
  localparam logic [7:0]  CNT_ONE       = 8'h01;

  // ********************************************************************
  // Enumerations.
  // ********************************************************************
  typedef enum logic [3:0] {
    SRC_OFF    = 4'b0000,
    SRC_RATE   = 4'b0001,
    SRC_TEMP   = 4'b0010,
    SRC_STATUS = 4'b0011
  } src_type;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_AVERAGE = 2'b01,
    ST_COMMIT  = 2'b10
  } null_state_type;

endpackage

/* File: verification/gyro_cal_alarm_assertions.sv */
// Concurrent checks on the ports of the calibration and alarm block.
`timescale 1ns/1ps
module gyro_cal_alarm_assertions (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        sample_valid,
  input wire logic        dout_oe,
  input wire logic        auto_bias_busy,
  input wire logic        flash_commit,
  input wire logic        data_clear,
  input wire logic [15:0] rate_output_high,
  input wire logic        digital_io_first_out,
  input wire logic        digital_io_first_oe,
  input wire logic        digital_io_second_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_busy_quiet: assert property (auto_bias_busy |-> !dout_oe)
    else $error("serial output enabled during bias null");
  a_null_commit: assert property ($fell(auto_bias_busy) |-> flash_commit)
    else $error("bias null ended without flash commit");
  a_commit_pulse: assert property (flash_commit |=> !flash_commit)
    else $error("flash commit longer than one cycle");
  a_clear_commit: assert property (data_clear |-> flash_commit)
    else $error("restore without flash commit");
  a_clear_zero: assert property (data_clear |-> rate_output_high == 16'h0000)
    else $error("restore left rate output nonzero");
  a_rate_hold: assert property ($changed(rate_output_high) |-> $past(sample_valid) || data_clear)
    else $error("rate output changed without a sample");
  a_pin_single: assert property (!(digital_io_first_oe && digital_io_second_oe))
    else $error("both indicator pins enabled");
  a_pin_idle: assert property (!digital_io_first_oe |-> !digital_io_first_out)
    else $error("disabled indicator pin driven high");
endmodule
bind gyro_cal_alarm gyro_cal_alarm_assertions u_gyro_cal_alarm_assertions (
  .clk(clk), .rst(rst), .sample_valid(sample_valid), .dout_oe(dout_oe),
  .auto_bias_busy(auto_bias_busy), .flash_commit(flash_commit), .data_clear(data_clear),
  .rate_output_high(rate_output_high), .digital_io_first_out(digital_io_first_out),
  .digital_io_first_oe(digital_io_first_oe), .digital_io_second_oe(digital_io_second_oe));

/* File: verification/gyro_cal_alarm_test.sv */
// Self-checking bench for the bias calibration and alarm monitor.
`timescale 1ns/1ps
module gyro_cal_alarm_test;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        sample_valid = 1'b0;
  logic [31:0] rate_raw = 32'h0;
  logic        sclk, cs_n, din, dout, oe, busy, fc, dc, o1, e1, o2, e2;
  wire         miso = oe ? dout : ~dout;
  logic [15:0] hi, lo, rd_data;
  int          miscompares = 0;
  int          checked = 0;
  always #12.5 clk = ~clk;
  gyro_spi_host u_gyro_spi_host (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(miso));
  gyro_cal_alarm u_gyro_cal_alarm (.clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .din(din),
    .dout(dout), .dout_oe(oe), .sample_valid(sample_valid), .rate_raw(rate_raw),
    .rate_filtered(32'h0), .temp_word(16'h0), .status_word(8'h0), .decimation_setting(5'h01),
    .rate_output_high(hi), .rate_output_low(lo), .flash_commit(fc), .data_clear(dc),
    .auto_bias_busy(busy), .digital_io_first_out(o1), .digital_io_first_oe(e1),
    .digital_io_second_out(o2), .digital_io_second_oe(e2));
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    logic [15:0] r;
    u_gyro_spi_host.xfer({1'b1, a + 7'h01, d[15:8]}, r);
    u_gyro_spi_host.xfer({1'b1, a, d[7:0]}, r);
  endtask
  task automatic rd(input logic [6:0] a);
    u_gyro_spi_host.xfer({1'b0, a, 8'h00}, rd_data);
    u_gyro_spi_host.xfer(16'h0000, rd_data);
  endtask
  task automatic smp(input logic [31:0] v);
    @(negedge clk);
    rate_raw = v;
    sample_valid = 1'b1;
    @(negedge clk);
    sample_valid = 1'b0;
    repeat (4) @(negedge clk);
  endtask
  task automatic t_regs;
    rd(gyro_cal_pkg::ADDR_ALM_CFG);
    chk("alarm_config reset", 16'h0000, rd_data);
    wr(gyro_cal_pkg::ADDR_ALM1_THR, 16'h0200);
    rd(gyro_cal_pkg::ADDR_ALM1_THR + 7'h01);
    chk("alarm1_threshold", 16'h0200, rd_data);
    rd(7'h0c);
    chk("unmapped read", 16'h0000, rd_data);
    $display("test regs done");
  endtask
  task automatic t_offset;
    wr(gyro_cal_pkg::ADDR_OFF_HIGH, 16'h0010);
    wr(gyro_cal_pkg::ADDR_OFF_LOW, 16'h8000);
    smp(32'h0100_8000);
    chk("rate_output_high", 16'h0111, hi);
    chk("rate_output_low", 16'h0000, lo);
    $display("test offset done");
  endtask
  task automatic t_alarm;
    wr(gyro_cal_pkg::ADDR_ALM_CFG, 16'h0117);
    smp(32'h0300_0000);
    chk("indicator on", 16'h0003, {13'h0, e1, o2, e2});
    rd(gyro_cal_pkg::ADDR_STATUS);
    chk("status alarm", 16'h0100, rd_data);
    smp(32'h0100_0000);
    chk("indicator off", 16'h0001, {13'h0, e1, o2, e2});
    rd(gyro_cal_pkg::ADDR_STATUS);
    chk("status clear", 16'h0000, rd_data);
    $display("test alarm done");
  endtask
  task automatic t_null;
    u_gyro_spi_host.xfer(16'ha801, rd_data);
    chk("busy at start", 16'h0001, {15'h0, busy});
    u_gyro_spi_host.xfer(16'h9055, rd_data);
    smp(32'h0100_8000);
    chk("busy mid average", 16'h0001, {15'h0, busy});
    smp(32'h0100_8000);
    chk("busy done", 16'h0000, {15'h0, busy});
    rd(gyro_cal_pkg::ADDR_OFF_HIGH);
    chk("null offset high", 16'hfeef, rd_data);
    rd(gyro_cal_pkg::ADDR_ALM1_THR);
    chk("threshold kept", 16'h0200, rd_data);
    $display("test null done");
  endtask
  task automatic t_restore;
    u_gyro_spi_host.xfer(16'ha802, rd_data);
    chk("rate after restore", 16'h0000, hi);
    rd(gyro_cal_pkg::ADDR_OFF_HIGH);
    chk("offset after restore", 16'h0000, rd_data);
    $display("test restore done");
  endtask
  task automatic t_roc;
    wr(gyro_cal_pkg::ADDR_ALM2_THR, 16'h0100);
    wr(gyro_cal_pkg::ADDR_ALM2_CNT, 16'h0002);
    wr(gyro_cal_pkg::ADDR_ALM_CFG, 16'h10a4);
    smp(32'h0100_0000);
    smp(32'h0300_0000);
    chk("roc window open", 16'h0006, {13'h0, e1, o1, e2});
    smp(32'h0300_0000);
    chk("roc indicator", 16'h0004, {13'h0, e1, o1, e2});
    rd(gyro_cal_pkg::ADDR_STATUS);
    chk("roc status", 16'h0200, rd_data);
    $display("test roc done");
  endtask
  task automatic t_abort;
    u_gyro_spi_host.xfer(16'ha801, rd_data);
    chk("busy before reset", 16'h0001, {15'h0, busy});
    @(negedge clk);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    chk("busy after reset", 16'h0000, {15'h0, busy});
    rd(gyro_cal_pkg::ADDR_ALM2_THR);
    chk("threshold after reset", 16'h0000, rd_data);
    $display("test abort done");
  endtask
  task automatic tally_and_finish;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    t_regs;
    t_offset;
    t_alarm;
    t_null;
    t_restore;
    t_roc;
    t_abort;
    tally_and_finish;
  end
  initial begin
    #2000000;
    miscompares++;
    tally_and_finish;
  end
endmodule

/* File: verification/gyro_spi_host.sv */
// Host processor model driving mode 3 serial frames.
`timescale 1ns/1ps
module gyro_spi_host (
  output logic      sclk,
  output logic      cs_n,
  output logic      din,
  input  wire logic dout
);
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    din  = 1'b0;
  end
  task automatic xfer(input logic [15:0] w, output logic [15:0] r);
    cs_n = 1'b0;
    #200;
    for (int i = 15; i >= 0; i--) begin
      sclk = 1'b0;
      din  = w[i];
      #100;
      sclk = 1'b1;
      #90;
      r = {r[14:0], dout};
      #10;
    end
    cs_n = 1'b1;
    din  = ~din;
    #200;
  endtask
endmodule
